// ---- smrc_core.sv ----
module smrc_core (
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      cke,
	input  wire logic                      cs_n,
	input  wire logic                      ras_n,
	input  wire logic                      cas_n,
	input  wire logic                      we_n,
	input  wire logic [1:0]                bank_select,
	input  wire logic [smrc_pkg::ROW_W-1:0] addr,
	output logic [smrc_pkg::MODE_W-1:0]    mode_q,
	output logic [smrc_pkg::COL_W-1:0]     col_q,
	output logic                           rd_valid_q,
	output logic                           wr_active_q,
	output logic [smrc_pkg::ROW_W-1:0]     refresh_row_q,
	output logic                           refresh_pulse_q,
	output logic                           self_refresh_q,
	output logic [3:0]                     bank_active_q,
	output logic                           illegal_q,
	output logic                           mode_busy_q
);
	import smrc_pkg::*;

	// ********************************************************
	// command decode
	// ********************************************************
	smrc_cmd_type cmd;
	wire          sel     = ~cs_n & cke & ~self_refresh_q;
	wire          any_act = |bank_active_q;
	wire [2:0]    bl_code = mode_q[BL_LSB +: 3];
	wire [2:0]    cl_code = mode_q[CL_LSB +: 3];
	wire          is_page = (bl_code == BL_PAGE);

	// deselect and self refresh both fall through to no operation
	always_comb begin
		cmd = CMD_NOP;
		if (sel) begin
			case ({ras_n, cas_n, we_n})
				3'b000: cmd = CMD_MRW;
				3'b001: cmd = CMD_REF;
				3'b010: cmd = CMD_PRE;
				3'b011: cmd = CMD_ACT;
				3'b100: cmd = CMD_WR;
				3'b101: cmd = CMD_RD;
				3'b110: cmd = CMD_STOP;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	// enable sampled low with refresh encoding selects self refresh
	wire self_go   = (cmd == CMD_REF) & ~cke;
	wire ref_raw   = ~cs_n & ~ras_n & ~cas_n & we_n & ~self_refresh_q;
	wire mrw_ok    = (cmd == CMD_MRW) & ~any_act;
	wire ref_ok    = (cmd == CMD_REF) & ~any_act;
	wire self_ok   = ref_raw & ~cke & ~any_act & ~self_refresh_q;
	wire bad_cmd   = ((cmd == CMD_MRW) | (cmd == CMD_REF)) & any_act;

	// ********************************************************
	// burst length and order
	// ********************************************************
	// length decode
	logic [9:0] blen;
	always_comb begin
		case (bl_code)
			BL_1:    blen = 10'h001;
			BL_2:    blen = 10'h002;
			BL_4:    blen = 10'h004;
			BL_8:    blen = 10'h008;
			BL_PAGE: blen = 10'(PAGE_COLS);
			default: blen = 10'h001;
		endcase
	end

	logic [COL_W-1:0] start_q;
	logic [9:0]       beat_q;
	logic [9:0]       len_q;
	wire  [COL_W-1:0] bmask = COL_W'(blen - 10'h001);
	// index of the column shown after the next edge, one past beat_q
	wire  [COL_W-1:0] beat  = beat_q[COL_W-1:0] + 9'h001;
	wire  [COL_W-1:0] seq_col = (start_q & ~bmask)
		| ((start_q + beat) & bmask);
	wire  [COL_W-1:0] ilv_col = start_q ^ (beat & bmask);
	wire  [COL_W-1:0] next_col = (mode_q[BT_BIT] && !is_page)
		? ilv_col : seq_col;
	wire  burst_end = !is_page && (beat_q + 10'h001 >= len_q);
	wire  [9:0] wlen = mode_q[WB_BIT] ? 10'h001 : blen;

	// ********************************************************
	// read latency pipeline
	// ********************************************************
	logic       rd_run_q;
	logic [2:0] rd_pipe_q;
	wire        lat3 = (cl_code == CL_3);
	wire        rd_out = lat3 ? rd_pipe_q[2] : rd_pipe_q[1];

	// ********************************************************
	// mode register and busy window
	// ********************************************************
	logic [1:0] busy_cnt_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q     <= MODE_RST;
			busy_cnt_q <= 2'h0;
		end else if (mrw_ok) begin
			mode_q     <= {addr[11], 1'b0, addr[9:0]};
			busy_cnt_q <= MRW_WAIT;
		end else if (busy_cnt_q != 2'h0) begin
			busy_cnt_q <= busy_cnt_q - 2'h1;
		end
	end

	// update takes two clocks to settle
	always_ff @(posedge clk) begin
		if (srst)
			mode_busy_q <= 1'b0;
		else
			mode_busy_q <= mrw_ok | (busy_cnt_q > 2'h1);
	end

	// ********************************************************
	// bank state
	// ********************************************************
	always_ff @(posedge clk) begin
		if (srst)
			bank_active_q <= 4'h0;
		else if (cmd == CMD_ACT)
			bank_active_q[bank_select] <= 1'b1;
		else if (cmd == CMD_PRE && addr[10])
			bank_active_q <= 4'h0;
		else if (cmd == CMD_PRE)
			bank_active_q[bank_select] <= 1'b0;
	end

	// ********************************************************
	// burst sequencer
	// ********************************************************
	// a new read or write restarts the burst at its column
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_run_q    <= 1'b0;
			wr_active_q <= 1'b0;
			beat_q      <= 10'h000;
			len_q       <= 10'h000;
			start_q     <= '0;
			col_q       <= '0;
		end else if (cmd == CMD_RD || cmd == CMD_WR) begin
			rd_run_q    <= (cmd == CMD_RD);
			wr_active_q <= (cmd == CMD_WR);
			beat_q      <= 10'h000;
			len_q       <= (cmd == CMD_RD) ? blen : wlen;
			start_q     <= addr[COL_W-1:0];
			col_q       <= addr[COL_W-1:0];
		end else if (cmd == CMD_STOP || cmd == CMD_PRE
			|| (rd_run_q | wr_active_q) && burst_end) begin
			rd_run_q    <= 1'b0;
			wr_active_q <= 1'b0;
		end else if (rd_run_q | wr_active_q) begin
			beat_q      <= beat_q + 10'h001;
			col_q       <= next_col;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_pipe_q  <= 3'h0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_pipe_q  <= {rd_pipe_q[1:0], rd_run_q & (cmd != CMD_STOP)
				& (cmd != CMD_PRE) & ~burst_end
				| (cmd == CMD_RD)};
			rd_valid_q <= rd_out;
		end
	end

	// ********************************************************
	// refresh counter and self refresh
	// ********************************************************
	// counter advance
	always_ff @(posedge clk) begin
		if (srst) begin
			refresh_row_q   <= '0;
			refresh_pulse_q <= 1'b0;
		end else begin
			refresh_pulse_q <= (ref_ok & ~self_go) | self_refresh_q;
			if ((ref_ok & ~self_go) | self_refresh_q)
				refresh_row_q <= refresh_row_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			self_refresh_q <= 1'b0;
		else if (self_ok)
			self_refresh_q <= 1'b1;
		else if (cke)
			self_refresh_q <= 1'b0;
	end

	// illegal command flag, sticky until reset
	always_ff @(posedge clk) begin
		if (srst)
			illegal_q <= 1'b0;
		else if (bad_cmd | (ref_raw & ~cke & any_act))
			illegal_q <= 1'b1;
	end
endmodule : smrc_core

// ---- smrc_pkg.sv ----
// Overview of operation
// - all strobes low writes mode register
// - burst length code decode, reserved codes
// - full page spans 512 columns, wraps
// - order bit selects sequential or interleaved below full page; full page is always sequential
// - sequential wraps block, interleaved xors beat
// - latency code two or three clocks
// - write mode bit forces single writes, except at full page length
// - selected all-high strobes is no operation
// - burst stop ends non-precharge bursts
// - read data stops after latency
// - deselect ignores strobes and address
// - auto refresh uses and advances counter
// - self refresh ignores all but enable
// - read data after latency, one per clock
package smrc_pkg;
	// ********************************************************
	// mode register fields
	// ********************************************************
	localparam int         MODE_W        = 12;
	localparam int         BL_LSB        = 0;
	localparam int         BT_BIT        = 3;
	localparam int         CL_LSB        = 4;
	localparam int         TM_LSB        = 7;
	localparam int         WB_BIT        = 9;
	localparam logic [2:0] BL_1          = 3'h0;
	localparam logic [2:0] BL_2          = 3'h1;
	localparam logic [2:0] BL_4          = 3'h2;
	localparam logic [2:0] BL_8          = 3'h3;
	localparam logic [2:0] BL_PAGE       = 3'h7;
	localparam logic [2:0] CL_2          = 3'h2;
	localparam logic [2:0] CL_3          = 3'h3;
	localparam int         PAGE_COLS     = 512;
	localparam int         COL_W         = 9;
	localparam int         ROW_W         = 12;
	localparam logic [1:0] MRW_WAIT      = 2'h2;
	localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
	// ********************************************************
	// decoded commands
	// ********************************************************
	typedef enum {CMD_NOP, CMD_MRW, CMD_REF, CMD_SELF, CMD_STOP,
		CMD_ACT, CMD_PRE, CMD_RD, CMD_WR} smrc_cmd_type;
endpackage : smrc_pkg

// ---- smrc_chk_sva.sv ----
module smrc_chk (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [11:0] addr,
	input wire logic [11:0] mode_q,
	input wire logic        rd_valid_q,
	input wire logic [11:0] refresh_row_q,
	input wire logic        self_refresh_q,
	input wire logic [3:0]  bank_active_q,
	input wire logic        illegal_q
);
	import smrc_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// command word and acceptance
	wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire       live = cke && !self_refresh_q;
	wire       idle = bank_active_q == 4'h0;
	// a10 is dropped from the stored word
	logic [11:0] mw_q;
	always_ff @(posedge clk) mw_q <= {addr[11], 1'b0, addr[9:0]};
	sequence mrw_s; live && cmd == 4'h0 && idle; endsequence
	sequence ref_s; live && cmd == 4'h1 && idle; endsequence
	mode_write_a: assert property (mrw_s |=> mode_q == mw_q)
		else $error("mode word not stored");
	busy_refuse_a: assert property ((live && !cmd[3] && !cmd[2] && !cmd[1]
		&& !idle) |=> illegal_q && $stable(mode_q))
		else $error("busy bank command not refused");
	deselect_a: assert property (cs_n && !self_refresh_q |=>
		$stable(mode_q) && $stable(refresh_row_q))
		else $error("deselect changed state");
	nop_idle_a: assert property (live && cmd == 4'h7 |=>
		$stable(mode_q) && $stable(refresh_row_q))
		else $error("no operation changed state");
	refresh_step_a: assert property (ref_s |=>
		refresh_row_q == $past(refresh_row_q) + 12'h1)
		else $error("refresh row not advanced");
	self_entry_a: assert property (!cke && !self_refresh_q && cmd == 4'h1
		&& idle |=> self_refresh_q)
		else $error("self refresh not entered");
	self_hold_a: assert property (self_refresh_q && !cke |=>
		self_refresh_q && $stable(mode_q))
		else $error("self refresh not held");
	burst_four_a: assert property ($rose(rd_valid_q) && mode_q[2:0] == BL_4
		|-> rd_valid_q [*4] ##1 !rd_valid_q)
		else $error("four word burst length wrong");
endmodule : smrc_chk
bind smrc_core smrc_chk u_chk (.clk, .srst, .cke, .cs_n, .ras_n, .cas_n,
	.we_n, .addr, .mode_q, .rd_valid_q, .refresh_row_q, .self_refresh_q,
	.bank_active_q, .illegal_q);

// ---- smrc_ctl_model.sv ----
module smrc_ctl (
	input  wire logic  clk,
	output logic       cke = 1'b1,
	output logic [3:0] cmd = 4'hf,
	output logic [1:0] bank_select = 2'h0,
	output logic [11:0] addr = 12'h000
);
	timeunit 1ns;
	timeprecision 1ns;
	// bank select
	// bank stays zero except around an activate; caller restores it
	task bank_t(input logic [1:0] b);
		bank_select = b;
	endtask : bank_t
	// one command per cycle, launched away from the sampling edge
	task cmd_t(input logic [3:0] c, input logic k, input logic [11:0] a);
		@(negedge clk);
		cmd = c;
		cke = k;
		addr = a;
	endtask : cmd_t
	// idle no operation
	// a don't-care address flips so stale values never look meaningful
	task nop(input int n);
		repeat (n) cmd_t(4'h7, 1'b1, ~addr);
	endtask : nop
endmodule : smrc_ctl

// ---- tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import smrc_pkg::*;
	logic        clk, srst, cke, rd_valid_q, wr_active_q, refresh_pulse_q;
	logic        self_refresh_q, illegal_q, mode_busy_q;
	logic [3:0]  c, bank_active_q;
	logic [1:0]  bank_select;
	logic [11:0] addr, mode_q, refresh_row_q, r;
	logic [8:0]  col_q;
	int          err_count = 0, n_checks = 0, cyc = 0;
	// mode word, start column and first four columns of each burst
	logic [11:0] tm [3] = '{12'h032, 12'h03a, 12'h027};
	logic [8:0]  ts [3][4] = '{'{1,2,3,0}, '{1,0,3,2}, '{510,511,0,1}};
	smrc_ctl u_ctl (.clk, .cke, .cmd(c), .bank_select, .addr);
	smrc_core dut (.clk, .srst, .cke, .cs_n(c[3]), .ras_n(c[2]),
		.cas_n(c[1]), .we_n(c[0]), .bank_select, .addr, .mode_q, .col_q,
		.rd_valid_q, .wr_active_q, .refresh_row_q, .refresh_pulse_q,
		.self_refresh_q, .bank_active_q, .illegal_q, .mode_busy_q);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard, far above the hundred or so cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			stop_test();
		end
	end
	task chk(input string nm, input logic [11:0] e, g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	initial begin
		srst = 1'b1;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		chk("mode", 12'h000, mode_q);
		// latency three suits any clock here
		u_ctl.cmd_t(4'h0, 1'b1, 12'h032);
		u_ctl.nop(1);
		chk("busy", 12'h1, {11'h0, mode_busy_q});
		u_ctl.nop(1);
		chk("mode", 12'h032, mode_q);
		r = refresh_row_q;
		u_ctl.cmd_t(4'h1, 1'b1, 12'hfff);
		u_ctl.nop(1);
		chk("pulse", 12'h1, {11'h0, refresh_pulse_q});
		u_ctl.nop(2);
		chk("row", r + 12'h1, refresh_row_q);
		for (int i = 0; i < 3; i++) begin
			u_ctl.cmd_t(4'h2, 1'b1, 12'h400);
			u_ctl.cmd_t(4'h0, 1'b1, tm[i]);
			u_ctl.nop(2);
			u_ctl.cmd_t(4'h3, 1'b1, 12'h000);
			u_ctl.nop(2);
			u_ctl.cmd_t(4'h5, 1'b1, {3'h0, ts[i][0]});
			for (int k = 0; k < 4; k++) begin
				u_ctl.nop(1);
				chk("column", {3'h0, ts[i][k]}, {3'h0, col_q});
				chk("valid", 12'(k == 3 || (k == 2 && i == 2)),
					{11'h0, rd_valid_q});
			end
			if (i == 2)
				u_ctl.cmd_t(4'h6, 1'b1, 12'h000);
			u_ctl.nop(8);
			chk("valid", 12'h0, {11'h0, rd_valid_q});
		end
		// refresh with enable low enters self refresh; a mode write inside it is ignored
		u_ctl.cmd_t(4'h2, 1'b1, 12'h400);
		u_ctl.cmd_t(4'h1, 1'b0, 12'h000);
		u_ctl.cmd_t(4'h0, 1'b0, 12'h000);
		u_ctl.cmd_t(4'h1, 1'b0, 12'h000);
		chk("self", 12'h1, {11'h0, self_refresh_q});
		u_ctl.cmd_t(4'h7, 1'b1, 12'h000);
		u_ctl.nop(4);
		chk("self", 12'h0, {11'h0, self_refresh_q});
		u_ctl.cmd_t(4'h8, 1'b1, 12'h000);
		u_ctl.nop(1);
		chk("mode", 12'h027, mode_q);
		u_ctl.bank_t(2'h2);
		u_ctl.cmd_t(4'h3, 1'b1, 12'h000);
		u_ctl.nop(1);
		u_ctl.bank_t(2'h0);
		chk("bank", 12'h4, {8'h0, bank_active_q});
		u_ctl.cmd_t(4'h0, 1'b1, 12'h032);
		u_ctl.nop(2);
		chk("mode", 12'h027, mode_q);
		chk("illegal", 12'h1, {11'h0, illegal_q});
		u_ctl.cmd_t(4'h4, 1'b1, 12'h000);
		u_ctl.nop(1);
		chk("write", 12'h1, {11'h0, wr_active_q});
		u_ctl.cmd_t(4'h6, 1'b1, 12'h000);
		u_ctl.nop(1);
		chk("write", 12'h0, {11'h0, wr_active_q});
		stop_test();
	end
endmodule : tb
